// >>> timer_channel_pkg.sv
// Package for the timer channel mode-select block: register map, fields, types
package timer_channel_pkg;

   // Register byte offsets on the AXI4-Lite bus
   localparam logic [4:0] ADDR_STATUS_CONTROL = 5'h00;
   localparam logic [4:0] ADDR_MATCH_VALUE    = 5'h04;
   localparam logic [4:0] ADDR_INT_STATUS     = 5'h08;
   localparam logic [4:0] ADDR_INT_MASK       = 5'h0C;
   localparam logic [4:0] ADDR_TIMER_CONTROL  = 5'h10;

   // Field positions in channel_status_control
   localparam int BIT_CHANNEL_FLAG     = 7;
   localparam int BIT_CHANNEL_IE       = 6;
   localparam int BIT_MODE_UPPER       = 5;
   localparam int BIT_MODE_LOWER       = 4;
   localparam int BIT_EDGE_LEVEL_UPPER = 3;
   localparam int BIT_EDGE_LEVEL_LOWER = 2;

   // Field positions in the interrupt and timer control registers
   localparam int BIT_INT_CHANNEL      = 0;
   localparam int BIT_CENTER_ALIGNED   = 0;

   // Reset values
   localparam logic [15:0] RESET_MATCH_VALUE = 16'h0000;
   localparam logic [3:0]  RESET_MODE_BITS   = 4'h0;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic mode_select_upper;
      logic mode_select_lower;
      logic edge_level_upper;
      logic edge_level_lower;
   } channel_cfg_t;

   typedef enum logic [2:0] {
      MODE_INPUT_CAPTURE,
      MODE_OUTPUT_COMPARE,
      MODE_EDGE_PWM,
      MODE_CENTER_PWM
   } channel_mode_t;

   // Shared timer signals coming from the module-level counter
   typedef struct packed {
      logic [15:0] count;
      logic        overflow;
      logic        count_down;
   } timer_count_t;

endpackage : timer_channel_pkg

// >>> timer_channel_mode_select.sv
// Timer channel: capture, compare, edge and center PWM, with AXI4-Lite registers
// Contract
// - Edge/level zero releases pin to GPIO.
// - Mode 00 captures rising, falling, either edge.
// - Mode 01 compare toggles, clears, sets pin.
// - Upper mode bit gives edge-aligned PWM.
// - Center-aligned select gives center-aligned PWM.
// - Lower mode bit, bit 4, picks capture/compare.
// - Edge/level field bits 3..2, meaning by mode.
// - Capture loads counter into value register.
// - Compare and PWM match against value register.
// - Reset clears the channel value register.
// - Pinless software timer keeps compare matching.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module timer_channel_mode_select
   import timer_channel_pkg::*;
#(
   parameter int VALUE_WIDTH = 16
) (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic [4:0]             s_axi_awaddr,
   input  wire logic [2:0]             s_axi_awprot,
   input  wire logic                   s_axi_awvalid,
   output      logic                   s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output      logic                   s_axi_wready,
   output      logic [1:0]             s_axi_bresp,
   output      logic                   s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [4:0]             s_axi_araddr,
   input  wire logic [2:0]             s_axi_arprot,
   input  wire logic                   s_axi_arvalid,
   output      logic                   s_axi_arready,
   output      logic [31:0]            s_axi_rdata,
   output      logic [1:0]             s_axi_rresp,
   output      logic                   s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   input  wire timer_count_t           timer_count,
   input  wire logic                   capture_in,
   output      logic                   pin_out,
   output      logic                   pin_oe,
   output      logic                   irq
);

   typedef struct packed {
      logic                   aw_held;
      logic [4:0]             aw_addr;
      logic                   w_held;
      logic [31:0]            w_data;
      logic [3:0]             w_strb;
      logic                   bvalid;
      logic [1:0]             bresp;
      logic                   rvalid;
      logic [31:0]            rdata;
      logic [1:0]             rresp;
      channel_cfg_t           cfg;
      logic [VALUE_WIDTH-1:0] match_value;
      logic                   center_aligned_select;
      logic                   flag;
      logic                   mask;
      logic                   pin_level;
      logic                   capture_prev;
   } state_t;

   localparam state_t RESET_STATE = '{
      aw_held:               1'b0,
      aw_addr:               5'h00,
      w_held:                1'b0,
      w_data:                32'h0000_0000,
      w_strb:                4'h0,
      bvalid:                1'b0,
      bresp:                 RESP_OKAY,
      rvalid:                1'b0,
      rdata:                 32'h0000_0000,
      rresp:                 RESP_OKAY,
      cfg:                   channel_cfg_t'(RESET_MODE_BITS),
      match_value:           VALUE_WIDTH'(RESET_MATCH_VALUE),
      center_aligned_select: 1'b0,
      flag:                  1'b0,
      mask:                  1'b0,
      pin_level:             1'b0,
      capture_prev:          1'b0
   };

   state_t st;
   state_t next_st;

   // Combined mode from center-aligned select and the two mode bits
   function automatic channel_mode_t decode_mode(input logic cas, input channel_cfg_t c);
      if (cas)
         return MODE_CENTER_PWM;
      else if (c.mode_select_upper)
         return MODE_EDGE_PWM;
      else if (c.mode_select_lower)
         return MODE_OUTPUT_COMPARE;
      else
         return MODE_INPUT_CAPTURE;
   endfunction

   // Byte-lane merge of write data into an old word
   function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i])
            res[i*8 +: 8] = data[i*8 +: 8];
      end
      return res;
   endfunction

   // Anything off the map answers with an error and has no effect
   function automatic logic addr_mapped(input logic [4:0] a);
      logic known;
      unique case (a)
         ADDR_STATUS_CONTROL,
         ADDR_MATCH_VALUE,
         ADDR_INT_STATUS,
         ADDR_INT_MASK,
         ADDR_TIMER_CONTROL: known = 1'b1;
         default:            known = 1'b0;
      endcase
      return known;
   endfunction

   // Edge/level pair as one code; its meaning depends on the mode
   function automatic logic [1:0] edge_level_code(input channel_cfg_t c);
      return {c.edge_level_upper, c.edge_level_lower};
   endfunction

   // Read view of one register; unmapped words read as zero
   function automatic logic [31:0] read_word(input logic [4:0] a, input state_t s, input logic [31:0] sc);
      logic [31:0] w;
      unique case (a)
         ADDR_STATUS_CONTROL: w = sc;
         ADDR_MATCH_VALUE:    w = 32'(s.match_value);
         ADDR_INT_STATUS:     w = {31'h0000_0000, s.flag};
         ADDR_INT_MASK:       w = {31'h0000_0000, s.mask};
         ADDR_TIMER_CONTROL:  w = {31'h0000_0000, s.center_aligned_select};
         default:             w = 32'h0000_0000;
      endcase
      return w;
   endfunction

   channel_mode_t mode;
   logic          pin_enabled;
   logic          match;
   logic          rise;
   logic          fall;
   logic          capture_event;
   logic          aw_fire;
   logic          w_fire;
   logic          ar_fire;
   logic          do_write;
   logic [4:0]    wr_addr;
   logic [31:0]   wr_data;
   logic [3:0]    wr_strb;
   logic [31:0]   scr_word;
   logic [31:0]   merged;
   logic          active_high;
   logic [1:0]    edge_code;

   always_comb begin
      mode        = decode_mode(st.center_aligned_select, st.cfg);
      edge_code   = edge_level_code(st.cfg);
      // Both edge/level bits low hands the pin back, whatever the mode
      pin_enabled = (edge_code != 2'b00);
      match       = (timer_count.count == 16'(st.match_value));
      // Edges seen against last cycle's sample
      rise        = capture_in & ~st.capture_prev;
      fall        = ~capture_in & st.capture_prev;
      capture_event = 1'b0;
      if (mode == MODE_INPUT_CAPTURE) begin
         unique case (edge_code)
            2'b01:   capture_event = rise;
            2'b10:   capture_event = fall;
            2'b11:   capture_event = rise | fall;
            2'b00:   capture_event = 1'b0;
         endcase
      end
      // High-true PWM when the lower edge/level bit is clear
      active_high = ~st.cfg.edge_level_lower;

      aw_fire = s_axi_awvalid & s_axi_awready;
      w_fire  = s_axi_wvalid & s_axi_wready;
      ar_fire = s_axi_arvalid & s_axi_arready;

      // Status/control word as software sees it
      scr_word = 32'h0000_0000;
      scr_word[BIT_CHANNEL_FLAG]     = st.flag;
      scr_word[BIT_CHANNEL_IE]       = st.mask;
      scr_word[BIT_MODE_UPPER]       = st.cfg.mode_select_upper;
      scr_word[BIT_MODE_LOWER]       = st.cfg.mode_select_lower;
      scr_word[BIT_EDGE_LEVEL_UPPER] = st.cfg.edge_level_upper;
      scr_word[BIT_EDGE_LEVEL_LOWER] = st.cfg.edge_level_lower;
   end

   always_comb begin
      next_st = st;
      merged  = 32'h0000_0000;

      // Write address and data are taken in either order
      if (aw_fire) begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = s_axi_awaddr;
      end
      if (w_fire) begin
         next_st.w_held = 1'b1;
         next_st.w_data = s_axi_wdata;
         next_st.w_strb = s_axi_wstrb;
      end
      do_write = next_st.aw_held & next_st.w_held;
      wr_addr  = next_st.aw_addr;
      wr_data  = next_st.w_data;
      wr_strb  = next_st.w_strb;

      if (s_axi_bvalid && s_axi_bready)
         next_st.bvalid = 1'b0;

      // Software writes first; hardware events below override them
      if (do_write) begin
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = addr_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
         unique case (wr_addr)
            ADDR_STATUS_CONTROL: begin
               merged = merge_strb(scr_word, wr_data, wr_strb);
               next_st.mask                   = merged[BIT_CHANNEL_IE];
               next_st.cfg.mode_select_upper  = merged[BIT_MODE_UPPER];
               next_st.cfg.mode_select_lower  = merged[BIT_MODE_LOWER];
               next_st.cfg.edge_level_upper   = merged[BIT_EDGE_LEVEL_UPPER];
               next_st.cfg.edge_level_lower   = merged[BIT_EDGE_LEVEL_LOWER];
               // Flag bit clears by writing one, same as the status register
               if (wr_strb[0] && wr_data[BIT_CHANNEL_FLAG])
                  next_st.flag = 1'b0;
            end
            ADDR_MATCH_VALUE: begin
               merged = merge_strb(32'(st.match_value), wr_data, wr_strb);
               next_st.match_value = merged[VALUE_WIDTH-1:0];
            end
            ADDR_INT_STATUS: begin
               if (wr_strb[0] && wr_data[BIT_INT_CHANNEL])
                  next_st.flag = 1'b0;
            end
            ADDR_INT_MASK: begin
               if (wr_strb[0])
                  next_st.mask = wr_data[BIT_INT_CHANNEL];
            end
            ADDR_TIMER_CONTROL: begin
               if (wr_strb[0])
                  next_st.center_aligned_select = wr_data[BIT_CENTER_ALIGNED];
            end
            default: begin
            end
         endcase
      end

      // Read channel: one outstanding read, data from flops
      if (s_axi_rvalid && s_axi_rready)
         next_st.rvalid = 1'b0;
      if (ar_fire) begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         next_st.rdata  = read_word(s_axi_araddr, st, scr_word);
      end

      // Input sample kept every cycle so a mode change sees a settled history;
      // a pin that moved just before the switch can still look like an edge
      next_st.capture_prev = capture_in;

      unique case (mode)
         MODE_INPUT_CAPTURE: begin
            if (capture_event) begin
               // Capture beats a same-cycle software write of the value
               next_st.match_value = VALUE_WIDTH'(timer_count.count);
               next_st.flag        = 1'b1;
            end
         end
         MODE_OUTPUT_COMPARE: begin
            if (match) begin
               // Flag still sets with the pin released: software timer
               next_st.flag = 1'b1;
               unique case (edge_code)
                  2'b01:   next_st.pin_level = ~st.pin_level;
                  2'b10:   next_st.pin_level = 1'b0;
                  2'b11:   next_st.pin_level = 1'b1;
                  2'b00:   next_st.pin_level = st.pin_level;
               endcase
            end
         end
         MODE_EDGE_PWM: begin
            // Period start drives the active level; match ends the pulse.
            // Match wins on overflow so a zero value gives zero duty.
            if (timer_count.overflow)
               next_st.pin_level = active_high;
            if (match) begin
               next_st.pin_level = ~active_high;
               next_st.flag      = 1'b1;
            end
         end
         MODE_CENTER_PWM: begin
            if (match) begin
               // Up-count match ends the pulse, down-count match starts it
               if (timer_count.count_down)
                  next_st.pin_level = active_high;
               else
                  next_st.pin_level = ~active_high;
               next_st.flag = 1'b1;
            end
         end
         default: begin
         end
      endcase
   end

   // Single register stage; next_st carries every decision
   always_ff @(posedge aclk) begin
      if (!aresetn)
         st <= RESET_STATE;
      else
         st <= next_st;
   end

   // Readies drop while a response waits, so one write is in flight
   assign s_axi_awready = ~st.aw_held & ~st.bvalid;
   assign s_axi_wready  = ~st.w_held & ~st.bvalid;
   assign s_axi_bvalid  = st.bvalid;
   assign s_axi_bresp   = st.bresp;
   assign s_axi_arready = ~st.rvalid;
   assign s_axi_rvalid  = st.rvalid;
   assign s_axi_rdata   = st.rdata;
   assign s_axi_rresp   = st.rresp;

   assign pin_out = st.pin_level;
   // Driven only by output modes with a nonzero edge/level field
   assign pin_oe  = pin_enabled & (mode != MODE_INPUT_CAPTURE);
   // Level interrupt straight from the sticky flag and its enable
   assign irq     = st.flag & st.mask;

endmodule // timer_channel_mode_select

// >>> timer_channel_mode_select_asserts.sv
// Port-level checker for the timer channel block
`timescale 1ns/1ns
module timer_channel_checker
   import timer_channel_pkg::*;
#(
   parameter int VALUE_WIDTH = 16
) (
   input wire logic         aclk,
   input wire logic         aresetn,
   input wire logic [4:0]   s_axi_awaddr,
   input wire logic         s_axi_awvalid,
   input wire logic         s_axi_awready,
   input wire logic [31:0]  s_axi_wdata,
   input wire logic         s_axi_wvalid,
   input wire logic         s_axi_wready,
   input wire timer_count_t timer_count,
   input wire logic         pin_out,
   input wire logic         pin_oe
);
   // Shadow of mode and match value; assumes full-word writes with both channels together
   logic [3:0]  cfg;
   logic        cen;
   logic [15:0] val;
   wire         wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire  [1:0]  ms    = cfg[3:2];
   wire  [1:0]  el    = cfg[1:0];
   wire         hit   = timer_count.count == val;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg <= 4'h0;
         cen <= 1'b0;
         val <= 16'h0000;
      end else if (wr_go) begin
         if (s_axi_awaddr == ADDR_STATUS_CONTROL) cfg <= s_axi_wdata[5:2];
         if (s_axi_awaddr == ADDR_TIMER_CONTROL) cen <= s_axi_wdata[0];
         if (s_axi_awaddr == ADDR_MATCH_VALUE) val <= s_axi_wdata[15:0];
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_release; el == 2'h0 |-> !pin_oe; endproperty
   a_release: assert property (p_release) else $error("pin driven with edge/level zero");
   property p_capture_oe; !cen && ms == 2'h0 |-> !pin_oe; endproperty
   a_capture_oe: assert property (p_capture_oe) else $error("pin driven in capture mode");
   property p_drive_oe; el != 2'h0 && (cen || ms != 2'h0) |-> pin_oe; endproperty
   a_drive_oe: assert property (p_drive_oe) else $error("pin not driven in output mode");
   property p_cmp_level; !cen && ms == 2'h1 && el[1] && hit |=> pin_out == $past(el[0]); endproperty
   a_cmp_level: assert property (p_cmp_level) else $error("compare level wrong");
   property p_cmp_toggle; !cen && ms == 2'h1 && el == 2'h1 && hit |=> pin_out != $past(pin_out); endproperty
   a_cmp_toggle: assert property (p_cmp_toggle) else $error("compare toggle missing");
   property p_edge_match; !cen && ms[1] && el != 2'h0 && hit |=> pin_out == $past(el[0]); endproperty
   a_edge_match: assert property (p_edge_match) else $error("edge pwm match level wrong");
   property p_edge_start; !cen && ms[1] && el != 2'h0 && timer_count.overflow && !hit |=> pin_out != $past(el[0]);
   endproperty
   a_edge_start: assert property (p_edge_start) else $error("edge pwm period start wrong");
   property p_center_up; cen && el != 2'h0 && hit && !timer_count.count_down |=> pin_out == $past(el[0]); endproperty
   a_center_up: assert property (p_center_up) else $error("center pwm up match wrong");
   property p_center_dn; cen && el != 2'h0 && hit && timer_count.count_down |=> pin_out != $past(el[0]); endproperty
   a_center_dn: assert property (p_center_dn) else $error("center pwm down match wrong");
endmodule // timer_channel_checker

bind timer_channel_mode_select timer_channel_checker #(.VALUE_WIDTH(VALUE_WIDTH)) u_checker (
   .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
   .s_axi_wvalid, .s_axi_wready, .timer_count, .pin_out, .pin_oe);

// >>> timer_far_side.sv
// Far-side model: shared timer counter and capture pin source
`timescale 1ns/1ns
module timer_far_side
   import timer_channel_pkg::*;
(
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         run,
   input  wire logic         center,
   input  wire logic [15:0]  top,
   input  wire logic         cap_req,
   output      timer_count_t timer_count,
   output      logic         capture_in
);
   // Counter holds while stopped, so a capture value is known in advance
   always_ff @(posedge aclk) begin
      capture_in <= cap_req;
      timer_count.overflow <= 1'b0;
      if (!aresetn) begin
         timer_count <= '0;
      end else if (run && !timer_count.count_down && timer_count.count == top) begin
         timer_count.count <= center ? top - 16'h0001 : 16'h0000;
         timer_count.count_down <= center;
         timer_count.overflow <= !center;
      end else if (run && timer_count.count_down && timer_count.count == 16'h0000) begin
         timer_count.count <= 16'h0001;
         timer_count.count_down <= 1'b0;
         timer_count.overflow <= 1'b1;
      end else if (run) begin
         timer_count.count <= timer_count.count_down ? timer_count.count - 16'h0001 : timer_count.count + 16'h0001;
      end
   end
endmodule // timer_far_side

// >>> timer_channel_mode_select_bench.sv
// Testbench for the timer channel block
`timescale 1ns/1ns
module timer_channel_mode_select_bench;
   import timer_channel_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid, awready, wready, arready;
   logic run, center, cap_req, capture_in, pin_out, pin_oe, irq;
   logic [4:0] awaddr, araddr;
   logic [31:0] wdata, rdata, x, n;
   logic [1:0] bresp, rresp;
   logic [15:0] top;
   timer_count_t tcount;
   int err_total, num_checks;
   timer_channel_mode_select dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .timer_count(tcount), .capture_in(capture_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .irq(irq));
   timer_far_side far (.aclk(aclk), .aresetn(aresetn), .run(run), .center(center), .top(top),
      .cap_req(cap_req), .timer_count(tcount), .capture_in(capture_in));
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      chk(rdata, ed);
      chk({30'h0, rresp}, {30'h0, er});
   endtask
   task automatic print_verdict;
      $display("Checks %0d, errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #200000;
      err_total++;
      print_verdict();
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, run, center, cap_req} = '0;
      {awaddr, araddr, wdata, err_total, num_checks} = '0;
      top = 16'h000F;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(ADDR_STATUS_CONTROL, 32'h0, RESP_OKAY);
      rd(ADDR_MATCH_VALUE, 32'h0, RESP_OKAY);
      chk({31'h0, pin_oe}, 32'h0);
      rd(5'h14, 32'h0, RESP_SLVERR);
      wr(5'h14, 32'h0000_00FF, RESP_SLVERR);
      wr(ADDR_MATCH_VALUE, 32'h0000_A55A, RESP_OKAY);
      rd(ADDR_MATCH_VALUE, 32'h0000_A55A, RESP_OKAY);
      run <= 1'b1;
      repeat (37) @(posedge aclk);
      run <= 1'b0;
      repeat (2) @(posedge aclk);
      x = {16'h0, tcount.count};
      // Each nonzero edge/level setting against both edge kinds
      for (int el = 1; el < 4; el++) begin
         for (int e = 0; e < 2; e++) begin
            cap_req <= !e[0];
            repeat (3) @(posedge aclk);
            wr(ADDR_MATCH_VALUE, 32'h0000_FFFF, RESP_OKAY);
            wr(ADDR_STATUS_CONTROL, el << 2, RESP_OKAY);
            cap_req <= e[0];
            repeat (4) @(posedge aclk);
            rd(ADDR_MATCH_VALUE, (e ? el[0] : el[1]) ? x : 32'h0000_FFFF, RESP_OKAY);
         end
      end
      rd(ADDR_INT_STATUS, 32'h1, RESP_OKAY);
      chk({31'h0, irq}, 32'h0);
      wr(ADDR_INT_MASK, 32'h1, RESP_OKAY);
      chk({31'h0, irq}, 32'h1);
      rd(ADDR_INT_MASK, 32'h1, RESP_OKAY);
      wr(ADDR_INT_STATUS, 32'h1, RESP_OKAY);
      chk({31'h0, irq}, 32'h0);
      run <= 1'b1;
      // Compare with every edge/level code, software timer included
      for (int el = 0; el < 4; el++) begin
         wr(ADDR_MATCH_VALUE, 32'h0000_0105, RESP_OKAY);
         wr(ADDR_STATUS_CONTROL, 32'hD0 | (el << 2), RESP_OKAY);
         rd(ADDR_STATUS_CONTROL, 32'h50 | (el << 2), RESP_OKAY);
         repeat (40) @(posedge aclk);
         rd(ADDR_INT_STATUS, 32'h0, RESP_OKAY);
         wr(ADDR_MATCH_VALUE, 32'h0000_0005, RESP_OKAY);
         repeat (40) @(posedge aclk);
         rd(ADDR_INT_STATUS, 32'h1, RESP_OKAY);
         chk({31'h0, irq}, 32'h1);
         chk({31'h0, pin_oe}, {31'h0, el != 0});
         if (el > 1) chk({31'h0, pin_out}, el[0]);
      end
      // Edge PWM: high-true then low-true duty over one period
      for (int el = 2; el > 0; el--) begin
         wr(ADDR_STATUS_CONTROL, 32'hE0 | (el << 2), RESP_OKAY);
         repeat (40) @(posedge aclk);
         n = 0;
         repeat (16) @(posedge aclk) n += pin_out;
         chk(n, el == 2 ? 5 : 11);
      end
      center <= 1'b1;
      wr(ADDR_TIMER_CONTROL, 32'h1, RESP_OKAY);
      rd(ADDR_TIMER_CONTROL, 32'h1, RESP_OKAY);
      wr(ADDR_STATUS_CONTROL, 32'hD8, RESP_OKAY);
      repeat (70) @(posedge aclk);
      n = 0;
      repeat (30) @(posedge aclk) n += pin_out;
      chk(n, 10);
      chk({31'h0, pin_oe}, 32'h1);
      print_verdict();
   end
endmodule // timer_channel_mode_select_bench
